// File: src/aidr_map.svh
`ifndef AIDR_MAP_SVH
`define AIDR_MAP_SVH

// Seven-bit bus address; read form 81h, write form 80h
`define AIDR_ADDR7        7'h40
`define AIDR_ROM_LEN      16
`define AIDR_FILL_BYTE    8'hFF
`define AIDR_PTR_RST      4'h0
// Master bit timing: half a bus clock period in system cycles
`define AIDR_HALF_NS      5000
`define AIDR_CLK_NS       25
`define AIDR_HALF_CYC     (`AIDR_HALF_NS / `AIDR_CLK_NS)

`endif

// File: src/aidr_pkg.sv
package aidr_pkg;
    typedef enum logic [2:0] {
        AIDR_S_IDLE,
        AIDR_S_ADDR,
        AIDR_S_AACK,
        AIDR_S_WDATA,
        AIDR_S_WACK,
        AIDR_S_RDATA,
        AIDR_S_RACK
    } aidr_slv_state_t;

    typedef enum logic [3:0] {
        AIDR_M_IDLE,
        AIDR_M_START,
        AIDR_M_BIT_LO,
        AIDR_M_BIT_HI,
        AIDR_M_ACK_LO,
        AIDR_M_ACK_HI,
        AIDR_M_STOP_LO,
        AIDR_M_STOP_HI,
        AIDR_M_DONE
    } aidr_mst_state_t;
endpackage

// File: src/aidr_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aidr_bus_if;
    logic scl_mst_o;
    logic scl_mst_oe;
    logic sda_mst_o;
    logic sda_mst_oe;
    logic sda_slv_o;
    logic sda_slv_oe;
    logic scl;
    logic sda;

    // Open-drain wired-AND with pull-ups
    assign scl = ~(scl_mst_oe & ~scl_mst_o);
    assign sda = ~((sda_mst_oe & ~sda_mst_o) | (sda_slv_oe & ~sda_slv_o));

    modport slave (
        input  scl,
        input  sda,
        output sda_slv_o,
        output sda_slv_oe
    );
    modport master (
        input  scl,
        input  sda,
        output scl_mst_o,
        output scl_mst_oe,
        output sda_mst_o,
        output sda_mst_oe
    );
endinterface
`default_nettype wire

// File: src/aidr_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "aidr_map.svh"

module aidr_slave #(
    parameter int ROM_LEN = `AIDR_ROM_LEN
) (
    // Clock and reset
    input  wire logic   clock_i,
    input  wire logic   arst_n_i,
    // Strap
    input  wire logic   id_responder_enable_strap_i,
    // Bus
    aidr_bus_if.slave   bus,
    // Status
    output logic        busy_o,
    output logic [3:0]  pointer_o
);
    localparam logic [7:0] ROM [0:15] = '{
        8'h44, 8'h50, 8'h2D, 8'h48, 8'h44, 8'h4D, 8'h49, 8'h20,
        8'h41, 8'h44, 8'h41, 8'h50, 8'h54, 8'h4F, 8'h52, 8'h04
    };

    logic [2:0] scl_sync_r;
    logic [2:0] sda_sync_r;
    logic       scl_r;
    logic       sda_r;
    logic       strap_r;
    logic [2:0] strap_sync_r;
    logic       byte_in_r;
    logic       scl_q_r;
    logic       sda_q_r;
    aidr_pkg::aidr_slv_state_t state_r;
    logic [7:0] shift_r;
    logic [2:0] bit_r;
    logic [4:0] ptr_r;
    logic       drive_low_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic [7:0] tx_byte;

    // Three-stage sync; a level counts once stages two and three agree
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], bus.scl};
            sda_sync_r <= {sda_sync_r[1:0], bus.sda};
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            if (scl_sync_r[1] == scl_sync_r[2])
                scl_r <= scl_sync_r[2];
            if (sda_sync_r[1] == sda_sync_r[2])
                sda_r <= sda_sync_r[2];
        end
    end

    // Strap is a pin; same three-stage filter as the bus lines
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_sync_r <= 3'h0;
            strap_r      <= 1'b0;
        end else begin
            strap_sync_r <= {strap_sync_r[1:0], id_responder_enable_strap_i};
            if (strap_sync_r[1] == strap_sync_r[2])
                strap_r <= strap_sync_r[2];
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_r;
            sda_q_r <= sda_r;
        end
    end

    assign scl_rise   = scl_r & ~scl_q_r;
    assign scl_fall   = ~scl_r & scl_q_r;
    assign start_cond = scl_r & scl_q_r & sda_q_r & ~sda_r;
    assign stop_cond  = scl_r & scl_q_r & ~sda_q_r & sda_r;

    always_comb begin
        if (ptr_r < 5'(ROM_LEN))
            tx_byte = ROM[ptr_r[3:0]];
        else
            tx_byte = `AIDR_FILL_BYTE;
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r     <= aidr_pkg::AIDR_S_IDLE;
            shift_r     <= 8'h00;
            bit_r       <= 3'h0;
            ptr_r       <= 5'h00;
            drive_low_r <= 1'b0;
            byte_in_r   <= 1'b0;
        end else if (!strap_r) begin
            state_r     <= aidr_pkg::AIDR_S_IDLE;
            drive_low_r <= 1'b0;
        end else if (stop_cond) begin
            state_r     <= aidr_pkg::AIDR_S_IDLE;
            drive_low_r <= 1'b0;
        end else if (start_cond) begin
            state_r     <= aidr_pkg::AIDR_S_ADDR;
            bit_r       <= 3'h0;
            byte_in_r   <= 1'b0;
            drive_low_r <= 1'b0;
        end else begin
            unique case (state_r)
                aidr_pkg::AIDR_S_IDLE: begin
                end
                aidr_pkg::AIDR_S_ADDR, aidr_pkg::AIDR_S_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_r};
                        bit_r   <= bit_r + 3'h1;
                        if (bit_r == 3'h7)
                            byte_in_r <= 1'b1;
                    end else if (scl_fall && byte_in_r) begin
                        // Eight bits in; the fall that closes a start
                        // carries no byte and must not be decoded
                        byte_in_r <= 1'b0;
                        if (state_r == aidr_pkg::AIDR_S_WDATA) begin
                            drive_low_r <= 1'b1;
                            state_r     <= aidr_pkg::AIDR_S_WACK;
                        end else if (shift_r[7:1] == `AIDR_ADDR7) begin
                            drive_low_r <= 1'b1;
                            state_r     <= aidr_pkg::AIDR_S_AACK;
                        end else begin
                            state_r <= aidr_pkg::AIDR_S_IDLE;
                        end
                    end
                end
                aidr_pkg::AIDR_S_AACK: begin
                    // Release or load only after SCL falls, so ack holds
                    if (scl_fall) begin
                        if (shift_r[0]) begin
                            state_r     <= aidr_pkg::AIDR_S_RDATA;
                            bit_r       <= 3'h0;
                            drive_low_r <= ~tx_byte[7];
                            shift_r     <= {tx_byte[6:0], 1'b1};
                        end else begin
                            state_r     <= aidr_pkg::AIDR_S_WDATA;
                            bit_r       <= 3'h0;
                            drive_low_r <= 1'b0;
                        end
                    end
                end
                aidr_pkg::AIDR_S_WACK: begin
                    // Offset value is dropped; pointer untouched
                    if (scl_fall) begin
                        state_r     <= aidr_pkg::AIDR_S_WDATA;
                        bit_r       <= 3'h0;
                        drive_low_r <= 1'b0;
                    end
                end
                aidr_pkg::AIDR_S_RDATA: begin
                    if (scl_fall) begin
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'h7) begin
                            drive_low_r <= 1'b0;
                            state_r     <= aidr_pkg::AIDR_S_RACK;
                        end else begin
                            drive_low_r <= ~shift_r[7];
                            shift_r     <= {shift_r[6:0], 1'b1};
                        end
                    end
                end
                aidr_pkg::AIDR_S_RACK: begin
                    if (scl_rise) begin
                        if (sda_r) begin
                            ptr_r   <= 5'(`AIDR_PTR_RST);
                            state_r <= aidr_pkg::AIDR_S_IDLE;
                        end else if (ptr_r != 5'h1F) begin
                            ptr_r <= ptr_r + 5'h01;
                        end
                    end else if (scl_fall) begin
                        state_r     <= aidr_pkg::AIDR_S_RDATA;
                        bit_r       <= 3'h0;
                        drive_low_r <= ~tx_byte[7];
                        shift_r     <= {tx_byte[6:0], 1'b1};
                    end
                end
                default: state_r <= aidr_pkg::AIDR_S_IDLE;
            endcase
        end
    end

    assign bus.sda_slv_o  = 1'b0;
    assign bus.sda_slv_oe = drive_low_r;
    assign busy_o         = (state_r != aidr_pkg::AIDR_S_IDLE);
    assign pointer_o      = ptr_r[3:0];
endmodule
`default_nettype wire

// File: src/aidr_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "aidr_map.svh"

module aidr_master #(
    parameter int HALF_CYC = `AIDR_HALF_CYC,
    parameter int MAX_LEN  = 32
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         arst_n_i,
    // Request
    input  wire logic         req_i,
    input  wire logic         write_offset_i,
    input  wire logic [7:0]   offset_i,
    input  wire logic [5:0]   read_len_i,
    // Answer
    output logic              ready_o,
    output logic              byte_valid_o,
    output logic [7:0]        byte_o,
    output logic              done_o,
    output logic              nack_o,
    // Bus
    aidr_bus_if.master        bus
);
    aidr_pkg::aidr_mst_state_t state_r;
    logic [15:0] tmr_r;
    logic [2:0]  sync_r;
    logic        sda_r;
    logic        scl_r;
    logic        sda_drv_r;
    logic [7:0]  sh_r;
    logic [2:0]  bit_r;
    logic [1:0]  phase_r;
    logic [5:0]  left_r;
    logic        rd_r;
    logic        woff_r;
    logic [7:0]  off_r;
    logic        nack_r;
    logic        bv_r;
    logic [7:0]  byte_r;
    logic        done_r;
    logic        tick;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_r <= 3'h7;
            sda_r  <= 1'b1;
        end else begin
            sync_r <= {sync_r[1:0], bus.sda};
            if (sync_r[1] == sync_r[2])
                sda_r <= sync_r[2];
        end
    end

    assign tick = (tmr_r == 16'(HALF_CYC - 1));

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i)
            tmr_r <= 16'h0000;
        else if (state_r == aidr_pkg::AIDR_M_IDLE || tick)
            tmr_r <= 16'h0000;
        else
            tmr_r <= tmr_r + 16'h0001;
    end

    // Phase 0: write address, 1: offset, 2: read address and the data that follows
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r   <= aidr_pkg::AIDR_M_IDLE;
            scl_r     <= 1'b1;
            sda_drv_r <= 1'b1;
            sh_r      <= 8'h00;
            bit_r     <= 3'h0;
            phase_r   <= 2'h0;
            left_r    <= 6'h00;
            rd_r      <= 1'b0;
            woff_r    <= 1'b0;
            off_r     <= 8'h00;
            nack_r    <= 1'b0;
            bv_r      <= 1'b0;
            byte_r    <= 8'h00;
            done_r    <= 1'b0;
        end else begin
            bv_r   <= 1'b0;
            done_r <= 1'b0;
            unique case (state_r)
                aidr_pkg::AIDR_M_IDLE: begin
                    // Waits for an idle bus before starting
                    if (req_i && sda_r && read_len_i != 6'h00) begin
                        woff_r  <= write_offset_i;
                        off_r   <= offset_i;
                        left_r  <= (read_len_i > 6'(MAX_LEN)) ?
                                   6'(MAX_LEN) : read_len_i;
                        nack_r  <= 1'b0;
                        phase_r <= write_offset_i ? 2'h0 : 2'h2;
                        state_r <= aidr_pkg::AIDR_M_START;
                    end
                end
                aidr_pkg::AIDR_M_START: begin
                    if (tick) begin
                        sda_drv_r <= 1'b0;
                        sh_r      <= {`AIDR_ADDR7, (phase_r == 2'h2)};
                        rd_r      <= 1'b0;
                        bit_r     <= 3'h0;
                        state_r   <= aidr_pkg::AIDR_M_BIT_LO;
                    end
                end
                aidr_pkg::AIDR_M_BIT_LO: begin
                    if (tick) begin
                        scl_r <= ~scl_r;
                        if (scl_r) begin
                            scl_r <= 1'b0;
                        end else begin
                            scl_r   <= 1'b1;
                            state_r <= aidr_pkg::AIDR_M_BIT_HI;
                        end
                        // Data set up while SCL is low
                        if (scl_r)
                            sda_drv_r <= rd_r ? 1'b1 : sh_r[7];
                    end
                end
                aidr_pkg::AIDR_M_BIT_HI: begin
                    if (tick) begin
                        scl_r <= 1'b0;
                        sh_r  <= {sh_r[6:0], sda_r};
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'h7) begin
                            sda_drv_r <= rd_r ? (left_r == 6'h01) : 1'b1;
                            state_r   <= aidr_pkg::AIDR_M_ACK_LO;
                        end else begin
                            sda_drv_r <= rd_r ? 1'b1 : sh_r[6];
                            state_r   <= aidr_pkg::AIDR_M_BIT_LO;
                        end
                    end
                end
                aidr_pkg::AIDR_M_ACK_LO: begin
                    if (tick) begin
                        scl_r   <= 1'b1;
                        state_r <= aidr_pkg::AIDR_M_ACK_HI;
                    end
                end
                aidr_pkg::AIDR_M_ACK_HI: begin
                    if (tick) begin
                        scl_r <= 1'b0;
                        bit_r <= 3'h0;
                        if (rd_r) begin
                            bv_r   <= 1'b1;
                            byte_r <= sh_r;
                            left_r <= left_r - 6'h01;
                            if (left_r == 6'h01) begin
                                sda_drv_r <= 1'b0;
                                state_r   <= aidr_pkg::AIDR_M_STOP_LO;
                            end else begin
                                sda_drv_r <= 1'b1;
                                state_r   <= aidr_pkg::AIDR_M_BIT_LO;
                            end
                        end else if (sda_r) begin
                            nack_r    <= 1'b1;
                            sda_drv_r <= 1'b0;
                            state_r   <= aidr_pkg::AIDR_M_STOP_LO;
                        end else if (phase_r == 2'h0) begin
                            phase_r   <= 2'h1;
                            sh_r      <= off_r;
                            sda_drv_r <= off_r[7];
                            state_r   <= aidr_pkg::AIDR_M_BIT_LO;
                        end else if (phase_r == 2'h1) begin
                            phase_r   <= 2'h2;
                            sda_drv_r <= 1'b0;
                            state_r   <= aidr_pkg::AIDR_M_STOP_LO;
                        end else begin
                            rd_r      <= 1'b1;
                            sda_drv_r <= 1'b1;
                            state_r   <= aidr_pkg::AIDR_M_BIT_LO;
                        end
                    end
                end
                aidr_pkg::AIDR_M_STOP_LO: begin
                    if (tick) begin
                        scl_r   <= 1'b1;
                        state_r <= aidr_pkg::AIDR_M_STOP_HI;
                    end
                end
                aidr_pkg::AIDR_M_STOP_HI: begin
                    if (tick) begin
                        sda_drv_r <= 1'b1;
                        if (phase_r == 2'h2 && !rd_r && !nack_r)
                            state_r <= aidr_pkg::AIDR_M_START;
                        else
                            state_r <= aidr_pkg::AIDR_M_DONE;
                    end
                end
                aidr_pkg::AIDR_M_DONE: begin
                    if (tick) begin
                        done_r  <= 1'b1;
                        state_r <= aidr_pkg::AIDR_M_IDLE;
                    end
                end
                default: state_r <= aidr_pkg::AIDR_M_IDLE;
            endcase
        end
    end

    assign bus.scl_mst_o  = 1'b0;
    assign bus.scl_mst_oe = ~scl_r;
    assign bus.sda_mst_o  = 1'b0;
    assign bus.sda_mst_oe = ~sda_drv_r;
    assign ready_o        = (state_r == aidr_pkg::AIDR_M_IDLE);
    assign byte_valid_o   = bv_r;
    assign byte_o         = byte_r;
    assign done_o         = done_r;
    assign nack_o         = nack_r;
endmodule
`default_nettype wire

// File: bench/aidr_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "aidr_map.svh"
module aidr_props (
    // Clock and reset
    input  wire logic   clock_i,
    input  wire logic   arst_n_i,
    // Strap
    input  wire logic   id_responder_enable_strap_i,
    // Bus lines
    input  wire logic   scl,
    input  wire logic   sda,
    input  wire logic   sda_mst_oe,
    input  wire logic   sda_slv_oe
);
    logic       scl_q_r;
    logic       sda_q_r;
    logic [3:0] bit_cnt_r;
    logic [5:0] byte_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] addr_r;
    logic       rise;
    logic       start_det;
    logic       strap;

    assign strap     = id_responder_enable_strap_i;
    assign rise      = scl && !scl_q_r;
    assign start_det = scl && scl_q_r && sda_q_r && !sda;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl;
            sda_q_r <= sda;
        end
    end

    // Bit slot 9 is the acknowledge; a start restarts the count
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_r  <= 4'h0;
            byte_cnt_r <= 6'h00;
        end else if (start_det) begin
            bit_cnt_r  <= 4'h0;
            byte_cnt_r <= 6'h00;
        end else if (rise) begin
            bit_cnt_r  <= (bit_cnt_r == 4'h9) ? 4'h1 : bit_cnt_r + 4'h1;
            byte_cnt_r <= (bit_cnt_r == 4'h9) ? byte_cnt_r + 6'h01 : byte_cnt_r;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_r <= 8'h00;
            addr_r  <= 8'h00;
        end else if (rise) begin
            shift_r <= {shift_r[6:0], sda};
            if (bit_cnt_r == 4'h8 && byte_cnt_r == 6'h00) begin
                addr_r <= shift_r;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_start;
        scl && scl_q_r && sda_q_r && !sda;
    endsequence
    sequence s_stop;
        scl && scl_q_r && !sda_q_r && sda;
    endsequence
    sequence s_ack_slot;
        rise && bit_cnt_r == 4'h8;
    endsequence

    a_addr_ack: assert property (s_ack_slot ##0 (byte_cnt_r == 6'h00)
        |-> sda == !(strap && shift_r[7:1] == `AIDR_ADDR7))
        else $error("address acknowledge wrong");
    a_offset_ack: assert property (s_ack_slot ##0
        (byte_cnt_r == 6'h01 && addr_r == 8'h80 && strap) |-> !sda)
        else $error("offset byte not acknowledged");
    a_ack_held: assert property (scl && scl_q_r && bit_cnt_r == 4'h9
        |-> $stable(sda))
        else $error("data moved during acknowledge pulse");
    a_nack_release: assert property (s_ack_slot ##0
        (byte_cnt_r != 6'h00 && addr_r[0] && sda)
        |-> ##6 (!sda_slv_oe)[*8] ##1 (!sda_slv_oe)[*8])
        else $error("slave drove data after master refusal");
    a_slave_scl_low: assert property (strap && $changed(sda_slv_oe)
        |-> !scl)
        else $error("slave moved data while clock high");
    a_strap_quiet: assert property ((!strap)[*6] |-> !sda_slv_oe)
        else $error("slave drove bus while disabled");
    a_start_master: assert property (s_start |-> sda_mst_oe)
        else $error("start not made by master");
    a_stop_idle: assert property (s_stop |=> (scl && sda)[*3])
        else $error("bus not free after stop");
endmodule
`default_nettype wire

// File: bench/aidr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aidr_map.svh"
module aidr_tb_top;
    localparam int         HALF = 8;
    localparam logic [7:0] ROM [16] = '{8'h44, 8'h50, 8'h2D, 8'h48, 8'h44,
        8'h4D, 8'h49, 8'h20, 8'h41, 8'h44, 8'h41, 8'h50, 8'h54, 8'h4F,
        8'h52, 8'h04};

    logic       clock_i;
    logic       arst_n_i;
    logic       strap;
    logic       req;
    logic       wr_off;
    logic [7:0] offset;
    logic [5:0] rlen;
    logic       ready;
    logic       byte_valid;
    logic [7:0] rd_byte;
    logic       done;
    logic       nack;
    logic       busy;
    logic [3:0] pointer;
    int         bad_count;
    int         num_checks;

    aidr_bus_if bus_if ();

    aidr_master #(.HALF_CYC(HALF), .MAX_LEN(32)) i_aidr_master (
        .clock_i        (clock_i),
        .arst_n_i       (arst_n_i),
        .req_i          (req),
        .write_offset_i (wr_off),
        .offset_i       (offset),
        .read_len_i     (rlen),
        .ready_o        (ready),
        .byte_valid_o   (byte_valid),
        .byte_o         (rd_byte),
        .done_o         (done),
        .nack_o         (nack),
        .bus            (bus_if.master)
    );

    aidr_slave i_aidr_slave (
        .clock_i                     (clock_i),
        .arst_n_i                    (arst_n_i),
        .id_responder_enable_strap_i (strap),
        .bus                         (bus_if.slave),
        .busy_o                      (busy),
        .pointer_o                   (pointer)
    );

    aidr_props i_aidr_props (
        .clock_i                     (clock_i),
        .arst_n_i                    (arst_n_i),
        .id_responder_enable_strap_i (strap),
        .scl                         (bus_if.scl),
        .sda                         (bus_if.sda),
        .sda_mst_oe                  (bus_if.sda_mst_oe),
        .sda_slv_oe                  (bus_if.sda_slv_oe)
    );

    always #12.5 clock_i = ~clock_i;

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One detection sequence; bytes are checked as they arrive
    task automatic txn(input logic wr, input logic [7:0] off,
                       input logic [5:0] len, input logic en);
        int         n;
        int         w;
        logic       fin;
        logic [7:0] exp;
        n = 0;
        w = 0;
        fin = 1'b0;
        @(negedge clock_i);
        strap = en;
        wr_off = wr;
        offset = off;
        rlen = len;
        req = 1'b1;
        do begin
            @(negedge clock_i);
            w++;
        end while (ready === 1'b1 && w < 100);
        req = 1'b0;
        w = 0;
        while (!fin && w < 20000) begin
            @(negedge clock_i);
            w++;
            if (byte_valid === 1'b1) begin
                exp = (n < 16) ? ROM[n] : `AIDR_FILL_BYTE;
                chk("read byte", exp, rd_byte);
                n++;
            end
            fin = (done === 1'b1);
        end
        chk("done seen", 8'h01, {7'h00, fin});
        chk("byte count", en ? {2'h0, len} : 8'h00, 8'(n));
        chk("refusal flag", {7'h00, !en}, {7'h00, nack});
        chk("pointer", {4'h0, `AIDR_PTR_RST}, {4'h0, pointer});
        chk("slave busy", 8'h00, {7'h00, busy});
        $display("test done: offset %0d len %0d strap %0d", wr, len, en);
    endtask

    initial begin
        clock_i = 1'b0;
        arst_n_i = 1'b0;
        strap = 1'b1;
        req = 1'b0;
        wr_off = 1'b0;
        offset = 8'h00;
        rlen = 6'h00;
        bad_count = 0;
        num_checks = 0;
        repeat (12) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        txn(1'b0, 8'h00, 6'h12, 1'b1);
        txn(1'b0, 8'h00, 6'h03, 1'b1);
        txn(1'b0, 8'h00, 6'h10, 1'b1);
        txn(1'b1, 8'h05, 6'h04, 1'b1);
        txn(1'b0, 8'h00, 6'h02, 1'b0);
        txn(1'b1, 8'h0F, 6'h01, 1'b0);
        txn(1'b0, 8'h00, 6'h01, 1'b1);
        wrap_up();
    end

    // Seven sequences take well under a millisecond at this bit rate
    initial begin
        #2000000;
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
